// >>> design/rwp_top.sv
// APB register block: protect register plus the guarded register groups it unlocks
// Overview of operation
// - bit 0 of the protect register lets writes reach the eight clock-control registers.
// - bit 1 of the protect register lets writes reach the two processor-mode registers.
// - bit 3 of the protect register lets writes reach the six voltage-detection registers.
// - an unlock bit stays set after a guarded write until software writes it to 0.
// - bit 7 of the protect register has no function and always reads 0.
// - a guarded register changes only while its group unlock bit is set.
`timescale 1ns/100ps
module rwp_top
(
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [rwp_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [rwp_pkg::DATA_W-1:0]   pwdata,
  output logic      [rwp_pkg::DATA_W-1:0]   prdata,
  output logic                              pready,
  output logic                              pslverr,
  output logic                              clock_group_unlock,
  output logic                              proc_mode_group_unlock,
  output logic                              voltage_group_unlock,
  output logic      [63:0]                  clock_group_regs,
  output logic      [15:0]                  proc_mode_regs,
  output logic      [47:0]                  voltage_group_regs
);
  import rwp_pkg::*;

  typedef struct packed
  {
    logic                       ack;
    logic                       slverr;
    logic [DATA_W-1:0]          rdata;
    logic [PROTECT_STORE_W-1:0] protect;
  } rwp_state_t;

  rwp_state_t       st;
  rwp_state_t       next_st;
  logic [IDX_W-1:0] idx;
  logic             in_window;
  logic             is_protect;
  logic             is_guarded;
  logic             mapped;
  logic             commit;
  rwp_group_t       grp;

  rwp_access_if acc ();

  rwp_guard u_guard
  (
    .acc (acc.guard)
  );

  rwp_store u_store
  (
    .pclk    (pclk),
    .presetn (presetn),
    .acc     (acc.store)
  );

  // ==========================================================================
  // address decode
  assign idx        = paddr[IDX_W+1:2];
  assign in_window  = (paddr[ADDR_W-1:IDX_W+2] == '0) && (paddr[1:0] == 2'h0);
  assign grp        = rwp_group_of(idx);
  assign is_protect = in_window && (idx == PROTECT_IDX);
  assign is_guarded = in_window && (grp != GRP_NONE);
  assign mapped     = is_protect || is_guarded;
  // a write takes effect only at the edge where pready is seen high
  assign commit     = psel && penable && st.ack && pwrite && mapped;

  assign acc.idx     = idx;
  assign acc.protect = st.protect;
  assign acc.wdata   = pwdata[7:0];
  // a locked write simply never raises the store strobe
  assign acc.wr_en   = commit && is_guarded && acc.grant;

  // ==========================================================================
  // bus state: one wait cycle so read data comes from a flop
  always_comb
  begin
    next_st     = st;
    next_st.ack = 1'b0;
    if (psel && penable && !st.ack)
    begin
      next_st.ack    = 1'b1;
      next_st.slverr = !mapped;
      next_st.rdata  = '0;
      if (!pwrite && is_protect)
      begin
        // top bit is never stored, so it reads back 0
        next_st.rdata = {{(DATA_W-PROTECT_STORE_W){1'b0}}, st.protect};
      end
      else if (!pwrite && is_guarded)
      begin
        next_st.rdata = {{(DATA_W-8){1'b0}}, acc.rd_byte};
      end
    end
    // only software clears an unlock bit, guarded writes leave it alone
    if (commit && is_protect)
    begin
      next_st.protect = pwdata[PROTECT_STORE_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st <= '{ack: 1'b0, slverr: 1'b0, rdata: '0, protect: PROTECT_RESET};
    end
    else
    begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // outputs
  assign pready                 = st.ack;
  assign pslverr                = st.ack && st.slverr;
  assign prdata                 = st.rdata;
  assign clock_group_unlock     = st.protect[CLOCK_UNLOCK_BIT];
  assign proc_mode_group_unlock = st.protect[PROC_UNLOCK_BIT];
  assign voltage_group_unlock   = st.protect[VOLT_UNLOCK_BIT];
  assign clock_group_regs       = acc.all_regs[63:0];
  assign proc_mode_regs         = acc.all_regs[79:64];
  assign voltage_group_regs     = acc.all_regs[127:80];

  // ==========================================================================
  // checks
  clock_write_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    (commit && grp == GRP_CLOCK && !st.protect[CLOCK_UNLOCK_BIT])
      |=> $stable(clock_group_regs))
    else $error("locked clock group changed");

  proc_write_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    (commit && grp == GRP_PROC && !st.protect[PROC_UNLOCK_BIT])
      |=> $stable(proc_mode_regs))
    else $error("locked processor mode group changed");

  volt_write_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    (commit && grp == GRP_VOLT && !st.protect[VOLT_UNLOCK_BIT])
      |=> $stable(voltage_group_regs))
    else $error("locked voltage group changed");

  unlock_persists_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clock_group_unlock && !(commit && is_protect)) |=> clock_group_unlock)
    else $error("clock unlock bit cleared without a protect write");

  top_bit_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pwrite && is_protect && pready) |-> (prdata[7] == 1'b0))
    else $error("protect register bit 7 read as 1");

  guarded_unlocked_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (commit && grp == GRP_CLOCK && st.protect[CLOCK_UNLOCK_BIT])
      |=> (clock_group_regs[$past(idx[2:0])*8 +: 8] == $past(pwdata[7:0])))
    else $error("unlocked clock write did not land");

  locked_write_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
    (commit && is_guarded && !acc.grant)
      |-> (!pslverr ##1 ($stable(acc.all_regs) && $stable(st.protect))))
    else $error("locked write changed state or raised an error");

  // ==========================================================================
  // bus handshake checks
  // the answer always comes after exactly one wait cycle, never sooner
  ready_one_cycle_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("pready stayed high for more than one cycle");

  ready_after_access_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready) |=> pready)
    else $error("access phase was not answered after one wait cycle");

  ready_needs_access_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!(psel && penable)) |=> !pready)
    else $error("pready rose without an access phase");

  unmapped_error_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready && !mapped) |=> pslverr)
    else $error("unmapped access did not raise pslverr");

  mapped_no_error_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready && mapped) |=> !pslverr)
    else $error("mapped access raised pslverr");

  error_with_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("pslverr high outside the answer cycle");

  // unmapped and write answers carry zero so stale read data never leaks
  unmapped_read_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready && !mapped) |=> (prdata == '0))
    else $error("unmapped access returned nonzero data");

  write_data_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready && pwrite) |=> (prdata == '0))
    else $error("write answer carried nonzero read data");

  // read data is only reloaded when a new access is prepared
  answer_data_holds_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!(psel && penable && !pready)) |=> $stable(prdata))
    else $error("read data moved outside an access");

  // ==========================================================================
  // protect register checks
  protect_write_lands_a: assert property (@(posedge pclk) disable iff (!presetn)
    (commit && is_protect)
      |=> ({voltage_group_unlock, proc_mode_group_unlock, clock_group_unlock}
           == {$past(pwdata[VOLT_UNLOCK_BIT]), $past(pwdata[PROC_UNLOCK_BIT]),
               $past(pwdata[CLOCK_UNLOCK_BIT])}))
    else $error("protect write did not set the unlock bits");

  // nothing but a software write to the protect register may move it
  protect_write_only_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!(commit && is_protect)) |=> $stable(st.protect))
    else $error("protect register changed without a protect write");

  guarded_keeps_unlock_a: assert property (@(posedge pclk) disable iff (!presetn)
    (commit && is_guarded) |=> $stable(st.protect))
    else $error("guarded write disturbed the protect register");

  proc_unlock_persists_a: assert property (@(posedge pclk) disable iff (!presetn)
    (proc_mode_group_unlock && !(commit && is_protect)) |=> proc_mode_group_unlock)
    else $error("processor mode unlock bit cleared without a protect write");

  volt_unlock_persists_a: assert property (@(posedge pclk) disable iff (!presetn)
    (voltage_group_unlock && !(commit && is_protect)) |=> voltage_group_unlock)
    else $error("voltage unlock bit cleared without a protect write");

  // the unlock outputs cannot move in the answer cycle, so they are the reference
  protect_read_value_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready && !pwrite && is_protect)
      |=> ((prdata[DATA_W-1:PROTECT_STORE_W] == '0)
           && (prdata[CLOCK_UNLOCK_BIT] == clock_group_unlock)
           && (prdata[PROC_UNLOCK_BIT] == proc_mode_group_unlock)
           && (prdata[VOLT_UNLOCK_BIT] == voltage_group_unlock)))
    else $error("protect register read back wrong");

  // ==========================================================================
  // guarded group checks
  proc_unlocked_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (commit && grp == GRP_PROC && st.protect[PROC_UNLOCK_BIT])
      |=> (proc_mode_regs[$past(idx[0])*8 +: 8] == $past(pwdata[7:0])))
    else $error("unlocked processor mode write did not land");

  volt_unlocked_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (commit && grp == GRP_VOLT && st.protect[VOLT_UNLOCK_BIT])
      |=> (voltage_group_regs[($past(idx) - VOLT_FIRST_IDX)*8 +: 8] == $past(pwdata[7:0])))
    else $error("unlocked voltage write did not land");

  guarded_read_value_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready && !pwrite && is_guarded)
      |=> (prdata == {24'h0, acc.all_regs[$past(idx[SLOT_W-1:0])*8 +: 8]}))
    else $error("guarded register read back wrong");

  unmapped_write_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && pready && pwrite && !mapped)
      |=> ($stable(acc.all_regs) && $stable(st.protect)))
    else $error("unmapped write changed state");

  read_no_change_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pwrite) |=> ($stable(acc.all_regs) && $stable(st.protect)))
    else $error("read changed state");

  idle_no_store_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!(psel && penable && pready)) |=> $stable(acc.all_regs))
    else $error("guarded register changed outside a write answer");

  // decoded here from the unlock outputs, independent of the guard module
  strobe_needs_unlock_a: assert property (@(posedge pclk) disable iff (!presetn)
    acc.wr_en |-> ((grp == GRP_CLOCK && clock_group_unlock)
                   || (grp == GRP_PROC && proc_mode_group_unlock)
                   || (grp == GRP_VOLT && voltage_group_unlock)))
    else $error("store strobe raised for a locked group");

  unlocked_no_error_a: assert property (@(posedge pclk) disable iff (!presetn)
    (commit && is_guarded && acc.grant) |-> !pslverr)
    else $error("unlocked guarded write raised pslverr");

  clock_write_isolated_a: assert property (@(posedge pclk) disable iff (!presetn)
    (commit && grp == GRP_CLOCK)
      |=> ($stable(proc_mode_regs) && $stable(voltage_group_regs)))
    else $error("clock group write touched another group");

  proc_write_isolated_a: assert property (@(posedge pclk) disable iff (!presetn)
    (commit && grp == GRP_PROC)
      |=> ($stable(clock_group_regs) && $stable(voltage_group_regs)))
    else $error("processor mode write touched another group");

  volt_write_isolated_a: assert property (@(posedge pclk) disable iff (!presetn)
    (commit && grp == GRP_VOLT)
      |=> ($stable(clock_group_regs) && $stable(proc_mode_regs)))
    else $error("voltage group write touched another group");

  // a protect write must never leak into the guarded store
  protect_write_isolated_a: assert property (@(posedge pclk) disable iff (!presetn)
    (commit && is_protect) |=> $stable(acc.all_regs))
    else $error("protect write changed a guarded register");
endmodule

// >>> design/rwp_pkg.sv
// package for the register write protection block: map, fields, reset values, decode
package rwp_pkg;

  // ==========================================================================
  // bus geometry
  localparam int unsigned ADDR_W   = 12;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned IDX_W    = 6;
  localparam int unsigned NPROT    = 16;
  localparam int unsigned SLOT_W   = 4;

  // ==========================================================================
  // register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] PROTECT_IDX     = 6'h0A;
  localparam logic [IDX_W-1:0] CLOCK_FIRST_IDX = 6'h10;
  localparam logic [IDX_W-1:0] CLOCK_LAST_IDX  = 6'h17;
  localparam logic [IDX_W-1:0] PROC_FIRST_IDX  = 6'h18;
  localparam logic [IDX_W-1:0] PROC_LAST_IDX   = 6'h19;
  localparam logic [IDX_W-1:0] VOLT_FIRST_IDX  = 6'h1A;
  localparam logic [IDX_W-1:0] VOLT_LAST_IDX   = 6'h1F;

  // ==========================================================================
  // protect register fields and reset values
  localparam int unsigned CLOCK_UNLOCK_BIT = 0;
  localparam int unsigned PROC_UNLOCK_BIT  = 1;
  localparam int unsigned VOLT_UNLOCK_BIT  = 3;
  localparam int unsigned PROTECT_STORE_W  = 7;
  localparam logic [PROTECT_STORE_W-1:0] PROTECT_RESET  = 7'h00;
  localparam logic [7:0]                 PROTECTED_RESET = 8'h00;

  // ==========================================================================
  // groups of guarded registers
  typedef enum logic [1:0]
  {
    GRP_NONE  = 2'b00,
    GRP_CLOCK = 2'b01,
    GRP_PROC  = 2'b10,
    GRP_VOLT  = 2'b11
  } rwp_group_t;

  function automatic rwp_group_t rwp_group_of(input logic [IDX_W-1:0] idx);
    rwp_group_t g;
    g = GRP_NONE;
    if (idx >= CLOCK_FIRST_IDX && idx <= CLOCK_LAST_IDX)
    begin
      g = GRP_CLOCK;
    end
    else if (idx >= PROC_FIRST_IDX && idx <= PROC_LAST_IDX)
    begin
      g = GRP_PROC;
    end
    else if (idx >= VOLT_FIRST_IDX && idx <= VOLT_LAST_IDX)
    begin
      g = GRP_VOLT;
    end
    return g;
  endfunction

endpackage

// >>> design/rwp_access_if.sv
// interface carrying guarded register accesses between control, guard and store
`timescale 1ns/100ps
interface rwp_access_if;
  import rwp_pkg::*;

  logic [IDX_W-1:0]           idx;
  logic [PROTECT_STORE_W-1:0] protect;
  logic                       grant;
  logic                       wr_en;
  logic [7:0]                 wdata;
  logic [7:0]                 rd_byte;
  logic [NPROT*8-1:0]         all_regs;

  modport ctrl  (output idx, output protect, output wr_en, output wdata,
                 input grant, input rd_byte, input all_regs);
  modport guard (input idx, input protect, output grant);
  modport store (input idx, input wr_en, input wdata, input grant,
                 output rd_byte, output all_regs);
endinterface

// >>> design/rwp_guard.sv
// write grant decode from the protect register and the target group
`timescale 1ns/100ps
module rwp_guard
(
  rwp_access_if.guard acc
);
  import rwp_pkg::*;

  // ==========================================================================
  // grant decode
  always_comb
  begin
    unique case (rwp_group_of(acc.idx))
      GRP_CLOCK: acc.grant = acc.protect[CLOCK_UNLOCK_BIT];
      GRP_PROC:  acc.grant = acc.protect[PROC_UNLOCK_BIT];
      GRP_VOLT:  acc.grant = acc.protect[VOLT_UNLOCK_BIT];
      GRP_NONE:  acc.grant = 1'b0;
    endcase
  end
endmodule

// >>> design/rwp_store.sv
// storage for the sixteen guarded byte registers
`timescale 1ns/100ps
module rwp_store
(
  input  wire logic   pclk,
  input  wire logic   presetn,
  rwp_access_if.store acc
);
  import rwp_pkg::*;

  typedef struct packed
  {
    logic [NPROT-1:0][7:0] regs;
  } rwp_store_t;

  rwp_store_t st;
  rwp_store_t next_st;
  logic [SLOT_W-1:0] slot;

  assign slot = acc.idx[SLOT_W-1:0];

  // ==========================================================================
  // update; the grant is checked again here so a stray strobe cannot land
  always_comb
  begin
    next_st = st;
    if (acc.wr_en && acc.grant)
    begin
      next_st.regs[slot] = acc.wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st <= '{regs: {NPROT{PROTECTED_RESET}}};
    end
    else
    begin
      st <= next_st;
    end
  end

  // reads ignore the protect bits
  assign acc.rd_byte  = st.regs[slot];
  assign acc.all_regs = st.regs;

  // ==========================================================================
  // checks
  store_update_a: assert property (@(posedge pclk) disable iff (!presetn)
    (acc.wr_en && acc.grant) |=> (st.regs[$past(slot)] == $past(acc.wdata)))
    else $error("granted write did not land in the store");
endmodule

// >>> verification/register_write_protection_tb.sv
// self-checking testbench for the register write protection block
`timescale 1ns/100ps
module register_write_protection_tb;
  import rwp_pkg::*;

  // ==========================================================================
  // stimulus and design
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        clk_unl;
  logic        proc_unl;
  logic        volt_unl;
  logic [63:0] clk_regs;
  logic [15:0] proc_regs;
  logic [47:0] volt_regs;
  logic [7:0]  mem [16];
  logic [6:0]  prot;
  logic [31:0] seed = 32'h9B46;
  int          n_mismatch = 0;
  int          num_checks = 0;
  int          bits [3] = '{0, 1, 3};

  always #2.5 pclk = ~pclk;

  rwp_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .clock_group_unlock(clk_unl), .proc_mode_group_unlock(proc_unl),
    .voltage_group_unlock(volt_unl), .clock_group_regs(clk_regs),
    .proc_mode_regs(proc_regs), .voltage_group_regs(volt_regs));

  // ==========================================================================
  // helpers
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    prot = 7'h00;
    foreach (mem[k]) mem[k] = 8'h00;
  endtask

  // outputs are sampled mid-cycle, after the write edge has settled
  task automatic chk_state();
    logic [127:0] e;
    @(negedge pclk);
    foreach (mem[k]) e[8*k +: 8] = mem[k];
    chk(clk_regs, e[63:0]);
    chk(64'(proc_regs), 64'(e[79:64]));
    chk(64'(volt_regs), 64'(e[127:80]));
    chk(64'({volt_unl, proc_unl, clk_unl}), 64'({prot[3], prot[1], prot[0]}));
  endtask

  // ==========================================================================
  // bus master: hold the request until pready is seen high at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    chk(64'(pready), 64'h1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // one transfer checked against the model, then the model is updated
  task automatic op(input logic w, input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    logic        map;
    logic [31:0] exp;
    int          i;
    int          g;
    i = int'(a[7:2]);
    map = a[1:0] == 2'b00 && a[11:8] == 4'h0 && (i == 10 || (i >= 16 && i <= 31));
    exp = !map ? 32'h0 : (i == 10) ? {25'h0, prot} : {24'h0, mem[(i - 16) % 16]};
    apb(w, a, d, rd, err);
    chk(64'(err), 64'(!map));
    if (!w)
      chk(64'(rd), 64'(exp));
    if (w && map && i == 10)
      prot = d[6:0];
    else if (w && map)
    begin
      g = (i < 24) ? CLOCK_UNLOCK_BIT : (i < 26) ? PROC_UNLOCK_BIT : VOLT_UNLOCK_BIT;
      if (prot[g])
        mem[i - 16] = d[7:0];
    end
  endtask

  // ==========================================================================
  // scenarios
  initial
  begin
    do_reset();
    chk_state();
    op(1'b0, 12'h028, 32'h0);
    for (int k = 0; k < 16; k++)
      op(1'b1, 12'h040 + 12'(4 * k), rnd());
    chk_state();
    foreach (bits[b])
    begin
      op(1'b1, 12'h028, 32'(1 << bits[b]));
      for (int k = 0; k < 16; k++)
        op(1'b1, 12'h040 + 12'(4 * k), rnd());
      chk_state();
      for (int k = 0; k < 16; k++)
        op(1'b0, 12'h040 + 12'(4 * k), 32'h0);
      op(1'b0, 12'h028, 32'h0);
    end
    op(1'b1, 12'h028, 32'hFFFF_FFFF);
    op(1'b0, 12'h028, 32'h0);
    op(1'b1, 12'h029, 32'h0);
    op(1'b1, 12'h02C, 32'h0);
    op(1'b0, 12'h140, 32'h0);
    op(1'b0, 12'h080, 32'h0);
    for (int n = 0; n < 300; n++)
    begin
      seed = rnd();
      op(seed[5], seed[4] ? 12'h040 + {6'h0, seed[3:0], 2'b00}
                          : (seed[3:1] == 3'b000 ? 12'h02C : 12'h028), rnd());
    end
    chk_state();
    do_reset();
    chk_state();
    op(1'b0, 12'h028, 32'h0);
    give_verdict();
  end

  initial
  begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    give_verdict();
  end
endmodule
